// ==== crbs_consts.svh ====
`ifndef CRBS_CONSTS_SVH
`define CRBS_CONSTS_SVH
// action code fields
`define CRBS_ACT_DATA_BIT    0
`define CRBS_ACT_READ_BIT    1
`define CRBS_ACT_TERM_BIT    3
// host address split
`define CRBS_ADDR_Y_MSB      15
`define CRBS_ADDR_Y_LSB      8
`define CRBS_ADDR_X_MSB      7
`define CRBS_ADDR_X_LSB      0
// vertical counter
`define CRBS_LAST_ROW_PAIR   8'h8f
`define CRBS_VPRELOAD        10'sh2dd
`define CRBS_VCNT_RESET      10'sh000
// timing counts
`define CRBS_COLUMN_INCREMENT_N_CYCLES     2'h2
`define CRBS_MODE_SYNC_STAGES 3
`endif

// ==== crbs_pkg.sv ====
package crbs_pkg;
  typedef enum logic [1:0] {
    CRBS_FRAME_XFER,
    CRBS_STORAGE
  } crbs_phase_e;
  typedef logic [3:0] crbs_ident_t;
endpackage

// ==== crbs_mode_sync.sv ====
`include "crbs_consts.svh"
module crbs_mode_sync
  import crbs_pkg::*;
(
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  // host side
  input  wire logic strobe_n_i,
  input  wire logic mode_bit_i,
  // result
  output logic      local_reset_n_o,
  output logic      leaving_o
);
  logic mode_q;
  logic mode_sync_q;
  logic lr_q;

  // the strobe only gates a capture flop; the captured bit, not the
  // strobe, crosses into the pixel clock domain through two stages
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      mode_q <= 1'b0;
    end else if (!strobe_n_i) begin
      mode_q <= mode_bit_i;
    end
  end

  // new bit lands in the local reset flop on the third edge
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      mode_sync_q <= 1'b0;
      lr_q        <= 1'b0;
    end else begin
      mode_sync_q <= mode_q;
      lr_q        <= mode_sync_q;
    end
  end

  assign local_reset_n_o = lr_q;
  // release pending: flag load forcing while the new bit ripples through
  assign leaving_o       = mode_q & ~lr_q;
endmodule

// ==== crbs_bitmap_ram.sv ====
`include "crbs_consts.svh"
module crbs_bitmap_ram
  import crbs_pkg::*;
#(
  parameter int AW = 16,
  parameter int DW = 4
)(
  // clock
  input  wire logic          ref_clk_i,
  // port
  input  wire logic          cs_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [DW-1:0] wdata_i,
  output logic      [DW-1:0] rdata_o
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge ref_clk_i) begin
    if (cs_i && we_i) begin
      mem[addr_i] <= wdata_i;
    end
  end

  // asynchronous read, like a static ram
  assign rdata_o = cs_i ? mem[addr_i] : '0;
endmodule

// ==== crbs_sequencer.sv ====
//==========================================================================
// Overview of operation
// R1 - code 0 no readout, 2 readout dump, 3 readout data, +8 terminate
// R2 - code zero at vertical gate keeps storage run asserted
// R3 - code 2 at vertical gate drops storage run until end of vertical cycle
// R4 - code 3 low bit at gate clears dump, enabling window identifiers
// R5 - window identifier from bitmap per pixel pair; zero marks border
// R6 - window active asserted whenever identifier is non-zero
// R7 - code zero after readout rows sets dump at gate, stopping identifiers
// R8 - last-row flag raised while row pair address marks final storage row
// R9 - after last row, preload pulse loads -291 and asserts image run
// R10 - terminate bit acts like last-row, only while image run deasserted
// R11 - host uses terminate code alone, never with readout code
// R12 - host loads 16-bit address: upper byte Y pair, lower byte X
// R13 - after each data access X counter enabled two cycles, adding two
// R14 - host enters local reset before bitmap access
// R15 - in local reset no timing, ccd standby, centroiding inhibited
// R16 - mode bit captured on strobe, local reset follows after 3 cycles
// R17 - power-on reset enters local reset
// R18 - address latched on strobe; sampled strobe makes counter load
// R19 - bitmap access strobes ignored unless local reset active
// R20 - in access mode host address overrides counter preloads
// R21 - read and write strobes combine into access, writes store bus data
// R22 - read drives ram data on low four bus bits only
// R23 - leaving local reset forces counter load until release
// R24 - host strobes are active low; bitmap strobes synchronised before use, mode strobe gates its capture flop directly
//==========================================================================
`include "crbs_consts.svh"
module crbs_sequencer
  import crbs_pkg::*;
#(
  parameter int ROW_LEN = 385
)(
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  // host command bus
  input  wire logic [15:0] host_data_bus_i,
  output logic      [15:0] host_data_bus_o,
  output logic      [15:0] host_data_bus_oe_o,
  input  wire logic        camera_mode_strobe_n_i,
  input  wire logic        bitmap_addr_strobe_n_i,
  input  wire logic        bitmap_write_strobe_n_i,
  input  wire logic        bitmap_read_strobe_n_i,
  // vertical timing
  input  wire logic        vertical_gate_period_i,
  input  wire logic        vertical_cycle_end_i,
  input  wire logic        pixel_step_i,
  // ccd control
  output logic             storage_run_n_o,
  output logic             image_run_n_o,
  output logic             dump_n_o,
  output logic             vertical_preload_n_o,
  output logic             final_row_flag_o,
  output logic             ccd_standby_o,
  output logic             centroid_inhibit_o,
  output logic             local_reset_n_o,
  // window output
  output crbs_ident_t      window_ident_o,
  output logic             window_active_n_o,
  output logic [7:0]       row_pair_address_o
);
  crbs_phase_e   phase_q;
  logic          lr_n;
  logic          leaving;
  logic [2:0]    addr_sync_q;
  logic [2:0]    wr_sync_q;
  logic [2:0]    rd_sync_q;
  logic [15:0]   addr_latch_q;
  logic          addr_load_q;
  logic [7:0]    xcnt_q;
  logic [7:0]    ycnt_q;
  logic signed [9:0] vcnt_q;
  logic [1:0]    column_increment_n_cnt_q;
  logic          column_increment_n;
  logic          counter_load_n;
  logic          bitmap_access_n;
  logic          acc_end;
  logic          ram_cs;
  logic          ram_we;
  logic [3:0]    ram_rdata;
  logic [3:0]    action;
  logic          terminate;
  logic          storage_run_n_n_q;
  logic          image_run_n_n_q;
  logic          dump_n_q;
  logic          vpl_n_q;
  logic [3:0]    rdata_q;
  logic          rd_active_q;
  crbs_ident_t   ident_q;
  logic          win_n_q;
  logic [8:0]    xpix_q;

  function automatic logic fell(input logic [2:0] s);
    fell = s[2] & ~s[1];
  endfunction

  function automatic logic rose(input logic [2:0] s);
    rose = ~s[2] & s[1];
  endfunction

  //========================================================================
  // local reset control
  crbs_mode_sync u_mode (
    .ref_clk_i       (ref_clk_i),
    .rst_i           (rst_i),
    .strobe_n_i      (camera_mode_strobe_n_i),
    .mode_bit_i      (host_data_bus_i[0]),
    .local_reset_n_o (lr_n),
    .leaving_o       (leaving)
  ); // see R16, see R17, see R24

  assign local_reset_n_o    = lr_n;
  assign ccd_standby_o      = ~lr_n;  // see R15
  assign centroid_inhibit_o = ~lr_n;  // see R15

  //========================================================================
  // host strobe synchronisers; bit 0 is the metastable stage
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      addr_sync_q <= 3'h7;
      wr_sync_q   <= 3'h7;
      rd_sync_q   <= 3'h7;
    end else begin
      addr_sync_q <= {addr_sync_q[1:0], bitmap_addr_strobe_n_i}; // see R24
      wr_sync_q   <= {wr_sync_q[1:0], bitmap_write_strobe_n_i};
      rd_sync_q   <= {rd_sync_q[1:0], bitmap_read_strobe_n_i};
    end
  end

  // strobes count only inside local reset, so stray bus cycles are harmless
  logic acc_ok;
  assign acc_ok = ~lr_n;  // see R19

  // address held from strobe end so ram update completes in its own time
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      addr_latch_q <= 16'h0000;
    end else if (acc_ok && rose(addr_sync_q)) begin
      addr_latch_q <= host_data_bus_i; // see R12, see R18
    end
  end

  // load one edge after the latch, so the counters never take a stale x
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      addr_load_q <= 1'b0;
    end else begin
      addr_load_q <= acc_ok && rose(addr_sync_q); // see R18
    end
  end

  // counter load: sampled address strobe, forced while leaving reset
  assign counter_load_n = ~(addr_load_q || leaving);
  // see R18, see R23

  assign bitmap_access_n = ~(acc_ok && (!wr_sync_q[1] || !rd_sync_q[1]));
  // see R21
  assign acc_end = acc_ok && (rose(wr_sync_q) || rose(rd_sync_q));

  // two-cycle column increment after each data access
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      column_increment_n_cnt_q <= 2'h0;
    end else if (acc_end) begin
      column_increment_n_cnt_q <= `CRBS_COLUMN_INCREMENT_N_CYCLES; // see R13
    end else if (column_increment_n_cnt_q != 2'h0) begin
      column_increment_n_cnt_q <= column_increment_n_cnt_q - 2'h1;
    end
  end
  assign column_increment_n = (column_increment_n_cnt_q == 2'h0);

  //========================================================================
  // bitmap address counters
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      xcnt_q <= 8'h00;
      ycnt_q <= 8'h00;
    end else if (!counter_load_n) begin
      if (leaving) begin
        xcnt_q <= 8'h00;
        ycnt_q <= 8'h00;
      end else begin
        // host address overrides normal preload values
        xcnt_q <= addr_latch_q[`CRBS_ADDR_X_MSB:`CRBS_ADDR_X_LSB]; // see R20
        ycnt_q <= addr_latch_q[`CRBS_ADDR_Y_MSB:`CRBS_ADDR_Y_LSB];
      end
    end else if (!lr_n) begin
      // normal sequencing control inhibited in access mode
      if (!column_increment_n) begin
        xcnt_q <= xcnt_q + 8'h01; // see R13, see R20
      end
    end else begin
      if (vertical_cycle_end_i) begin
        xcnt_q <= 8'h00;
      end else if (pixel_step_i && !storage_run_n_n_q && storage_run_n_n_q == 1'b0
                   && xpix_q[0]) begin
        xcnt_q <= xcnt_q + 8'h01;
      end
      if (!vpl_n_q) begin
        ycnt_q <= 8'h00;
      end else if (vertical_cycle_end_i && image_run_n_n_q && vcnt_q[0]) begin
        ycnt_q <= ycnt_q + 8'h01;
      end
    end
  end

  // pixel position within a row, lsb picks the pixel of a pair
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || vertical_cycle_end_i || !lr_n) begin
      xpix_q <= 9'h000;
    end else if (pixel_step_i && xpix_q != 9'(ROW_LEN - 1)) begin
      xpix_q <= xpix_q + 9'h001;
    end
  end

  assign row_pair_address_o = ycnt_q;

  //========================================================================
  // bitmap ram
  assign ram_cs = (~bitmap_access_n) | (lr_n & image_run_n_n_q); // see R21
  assign ram_we = acc_ok && fell(wr_sync_q);

  crbs_bitmap_ram #(.AW(16), .DW(4)) u_ram (
    .ref_clk_i (ref_clk_i),
    .cs_i      (ram_cs),
    .we_i      (ram_we),
    .addr_i    ({ycnt_q, xcnt_q}),
    .wdata_i   (host_data_bus_i[3:0]),
    .rdata_o   (ram_rdata)
  );

  // read back: low four bits only; upper bits never driven
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rdata_q     <= 4'h0;
      rd_active_q <= 1'b0;
    end else begin
      rd_active_q <= acc_ok && !rd_sync_q[1];
      if (acc_ok && !rd_sync_q[1]) begin
        rdata_q <= ram_rdata; // see R22
      end
    end
  end
  assign host_data_bus_o    = {12'h000, rdata_q};
  assign host_data_bus_oe_o = {12'h000, {4{rd_active_q}}}; // see R22

  //========================================================================
  // row sequencing
  assign action    = ram_rdata; // see R1
  assign terminate = (ycnt_q == `CRBS_LAST_ROW_PAIR && vcnt_q[0])
                   | (action[`CRBS_ACT_TERM_BIT] & image_run_n_n_q); // see R10
  assign final_row_flag_o = (ycnt_q == `CRBS_LAST_ROW_PAIR) && lr_n;
  // see R8

  always_ff @(posedge ref_clk_i) begin
    if (rst_i || !lr_n) begin
      vcnt_q <= `CRBS_VCNT_RESET;
    end else if (!vpl_n_q) begin
      vcnt_q <= `CRBS_VPRELOAD; // see R9
    end else if (vertical_cycle_end_i) begin
      vcnt_q <= vcnt_q + 10'sd1;
    end
  end

  // preload pulse during the gate once the final row or terminate is seen
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || !lr_n) begin
      vpl_n_q <= 1'b1;
    end else begin
      vpl_n_q <= ~(vertical_gate_period_i && terminate && image_run_n_n_q
                   && vpl_n_q); // see R9, see R10
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i || !lr_n) begin
      phase_q  <= CRBS_FRAME_XFER;
      image_run_n_n_q <= 1'b0;
      storage_run_n_n_q <= 1'b0;
    end else if (!vpl_n_q) begin
      phase_q  <= CRBS_FRAME_XFER;
      image_run_n_n_q <= 1'b0; // see R9
      storage_run_n_n_q <= 1'b0;
    end else begin
      unique case (phase_q)
        CRBS_FRAME_XFER: begin
          if (vcnt_q == `CRBS_VCNT_RESET && vertical_cycle_end_i) begin
            phase_q  <= CRBS_STORAGE;
            image_run_n_n_q <= 1'b1;
          end
        end
        CRBS_STORAGE: begin
          if (vertical_gate_period_i) begin
            // readout bit clear keeps storage run asserted
            storage_run_n_n_q <= action[`CRBS_ACT_READ_BIT]; // see R2, see R3
          end else if (vertical_cycle_end_i) begin
            storage_run_n_n_q <= 1'b0;
          end
        end
      endcase
    end
  end

  // dump indication from the data and readout bits at the gate
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || !lr_n) begin
      dump_n_q <= 1'b0;
    end else if (vertical_gate_period_i) begin
      dump_n_q <= image_run_n_n_q && action[`CRBS_ACT_DATA_BIT]
                  && action[`CRBS_ACT_READ_BIT]; // see R4, see R7
    end
  end

  //========================================================================
  // window identifiers
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || !lr_n) begin
      ident_q <= 4'h0;
      win_n_q <= 1'b1;
    end else begin
      ident_q <= dump_n_q ? ram_rdata : 4'h0; // see R5
      win_n_q <= !(dump_n_q && ram_rdata != 4'h0); // see R6
    end
  end

  assign window_ident_o       = ident_q;
  assign window_active_n_o    = win_n_q;
  assign storage_run_n_o      = storage_run_n_n_q | ~lr_n;   // see R15
  assign image_run_n_o        = image_run_n_n_q | ~lr_n;
  assign dump_n_o             = dump_n_q;
  assign vertical_preload_n_o = vpl_n_q;
endmodule

// ==== crbs_sequencer_chk.sv ====
// ==========
// port checks
module crbs_sequencer_chk
  import crbs_pkg::*;
(
  // clock and reset
  input wire logic        ref_clk_i,
  input wire logic        rst_i,
  // host bus
  input wire logic [15:0] host_data_bus_i,
  input wire logic [15:0] host_data_bus_oe_o,
  input wire logic        camera_mode_strobe_n_i,
  input wire logic        bitmap_read_strobe_n_i,
  // ccd and window
  input wire logic        storage_run_n_o,
  input wire logic        image_run_n_o,
  input wire logic        final_row_flag_o,
  input wire logic        ccd_standby_o,
  input wire logic        centroid_inhibit_o,
  input wire logic        local_reset_n_o,
  input wire crbs_ident_t window_ident_o,
  input wire logic        window_active_n_o,
  input wire logic [7:0]  row_pair_address_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  a_reset_enter : assert property (disable iff (1'b0)
    rst_i |=> !local_reset_n_o) else $error("reset left camera running");
  a_mode_follow : assert property ($fell(camera_mode_strobe_n_i) |->
    ##3 (local_reset_n_o == $past(host_data_bus_i[0], 3)))
    else $error("local reset does not follow mode bit");
  a_run_hold : assert property (!local_reset_n_o &&
    $past(!local_reset_n_o) |-> storage_run_n_o && image_run_n_o)
    else $error("run active in local reset");
  a_standby_tie : assert property (
    ccd_standby_o == !local_reset_n_o && centroid_inhibit_o == ccd_standby_o)
    else $error("standby does not match local reset");
  a_oe_cause : assert property (host_data_bus_oe_o != 16'h0000 |->
    !$past(bitmap_read_strobe_n_i, 3)) else $error("bus driven without read");
  a_read_drive : assert property ($fell(bitmap_read_strobe_n_i) &&
    !local_reset_n_o |-> ##3 host_data_bus_oe_o == 16'h000f)
    else $error("read does not drive low nibble");
  a_oe_refused : assert property (host_data_bus_oe_o != 16'h0000 |->
    !local_reset_n_o) else $error("bus driven while running");
  a_final_row : assert property (final_row_flag_o ==
    (row_pair_address_o == 8'h8f && local_reset_n_o))
    else $error("final row flag wrong");
  a_win_active : assert property (
    window_active_n_o == (window_ident_o == 4'h0))
    else $error("window active wrong");

  c_read : cover property (host_data_bus_oe_o == 16'h000f);
  c_leave : cover property ($rose(local_reset_n_o));
  c_enter : cover property ($fell(local_reset_n_o));
endmodule

bind crbs_sequencer crbs_sequencer_chk u_chk (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i),
  .host_data_bus_i(host_data_bus_i),
  .host_data_bus_oe_o(host_data_bus_oe_o),
  .camera_mode_strobe_n_i(camera_mode_strobe_n_i),
  .bitmap_read_strobe_n_i(bitmap_read_strobe_n_i),
  .storage_run_n_o(storage_run_n_o), .image_run_n_o(image_run_n_o),
  .final_row_flag_o(final_row_flag_o), .ccd_standby_o(ccd_standby_o),
  .centroid_inhibit_o(centroid_inhibit_o),
  .local_reset_n_o(local_reset_n_o), .window_ident_o(window_ident_o),
  .window_active_n_o(window_active_n_o),
  .row_pair_address_o(row_pair_address_o)
);

// ==== crbs_host_model.sv ====
// ==========
// control processor on the command bus
module crbs_host_model (
  // clock
  input  wire logic        ref_clk_i,
  // bus from device
  input  wire logic [15:0] bus_o_i,
  input  wire logic [15:0] bus_oe_i,
  // bus to device
  output logic      [15:0] bus_i_o,
  output logic      [3:0]  strobe_n_o,
  output logic      [15:0] rd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] drv_q;
  // undriven lines show the inverse of the last value, never stale data
  assign bus_i_o = (bus_oe_i & bus_o_i) | (~bus_oe_i & drv_q);
  initial begin
    drv_q = 16'h0000;
    strobe_n_o = 4'hf;
    rd_o = 16'h0000;
  end
  // sel: 0 mode, 1 address, 2 write, 3 read
  task automatic access(input logic [1:0] sel, input logic [15:0] d);
    @(posedge ref_clk_i);
    drv_q <= d;
    strobe_n_o[sel] <= 1'b0;
    repeat (5) @(posedge ref_clk_i);
    rd_o <= bus_i_o;
    strobe_n_o[sel] <= 1'b1;
    // data outlives the strobe so the address latch still sees it
    repeat (4) @(posedge ref_clk_i);
    drv_q <= ~d;
    repeat (2) @(posedge ref_clk_i);
  endtask
endmodule

// ==== crbs_sequencer_tb.sv ====
module crbs_sequencer_tb import crbs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // signals
  logic        ref_clk_i, rst_i;
  logic [15:0] bus_i, bus_o, bus_oe, rd;
  logic [3:0]  stb_n;
  logic        storage_run_n_n, image_run_n_n, dump_n, vpl_n, last_row;
  logic        standby, cinh, lrst_n, win_n;
  crbs_ident_t ident;
  logic [7:0]  row_pair;
  logic        vertical_gate_period, vend;
  int          fails, n_tests;

  always #5 ref_clk_i = ~ref_clk_i;

  crbs_sequencer uut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .host_data_bus_i(bus_i),
    .host_data_bus_o(bus_o), .host_data_bus_oe_o(bus_oe),
    .camera_mode_strobe_n_i(stb_n[0]), .bitmap_addr_strobe_n_i(stb_n[1]),
    .bitmap_write_strobe_n_i(stb_n[2]), .bitmap_read_strobe_n_i(stb_n[3]),
    .vertical_gate_period_i(vertical_gate_period), .vertical_cycle_end_i(vend),
    .pixel_step_i(1'b0), .storage_run_n_o(storage_run_n_n), .image_run_n_o(image_run_n_n),
    .dump_n_o(dump_n), .vertical_preload_n_o(vpl_n),
    .final_row_flag_o(last_row), .ccd_standby_o(standby),
    .centroid_inhibit_o(cinh), .local_reset_n_o(lrst_n),
    .window_ident_o(ident), .window_active_n_o(win_n),
    .row_pair_address_o(row_pair));

  crbs_host_model host (
    .ref_clk_i(ref_clk_i), .bus_o_i(bus_o), .bus_oe_i(bus_oe),
    .bus_i_o(bus_i), .strobe_n_o(stb_n), .rd_o(rd));

  // ==========
  // checking
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string m);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ==========
  // scenarios
  task automatic t_reset();
    chk({15'h0, lrst_n}, 16'h0000, "local reset at start");
    chk({12'h0, storage_run_n_n, image_run_n_n, standby, cinh}, 16'h000f, "idle ccd");
    chk(bus_oe, 16'h0000, "bus released");
    $display("test reset done");
  endtask

  task automatic t_access();
    host.access(2'd1, 16'h1240);
    chk({8'h00, row_pair}, 16'h0012, "row pair from address");
    host.access(2'd2, 16'h000a);
    host.access(2'd2, 16'h0005);
    host.access(2'd2, 16'h000c);
    host.access(2'd1, 16'h1242);
    // host drives ones into the low nibble, so a missing drive shows
    host.access(2'd3, 16'hffff);
    chk({12'h0, rd[3:0]}, 16'h0005, "read after step");
    host.access(2'd3, 16'hffff);
    chk({12'h0, rd[3:0]}, 16'h000c, "read second step");
    $display("test access done");
  endtask

  task automatic t_run();
    host.access(2'd0, 16'h0001);
    chk({15'h0, lrst_n}, 16'h0001, "running after mode");
    chk({14'h0, standby, cinh}, 16'h0000, "standby cleared");
    chk({8'h00, row_pair}, 16'h0000, "counters reloaded");
    host.access(2'd3, 16'h0009);
    chk({12'h0, rd[3:0]}, 16'h0009, "read refused");
    host.access(2'd0, 16'h0000);
    chk({15'h0, lrst_n}, 16'h0000, "back in local reset");
    $display("test run done");
  endtask

  // one-cycle gate or cycle-end pulse; vpl_at is the preload one edge on
  task automatic vpulse(input logic gate, output logic vpl_at);
    @(posedge ref_clk_i);
    vertical_gate_period <= gate;
    vend  <= !gate;
    @(posedge ref_clk_i);
    vertical_gate_period <= 1'b0;
    vend  <= 1'b0;
    @(posedge ref_clk_i);
    vpl_at = vpl_n;
    repeat (2) @(posedge ref_clk_i);
  endtask

  task automatic t_frame();
    logic vpl_at;
    host.access(2'd1, 16'h0000);
    host.access(2'd2, 16'h0003);
    host.access(2'd1, 16'h0100);
    host.access(2'd2, 16'h0008);
    host.access(2'd0, 16'h0001);
    vpulse(1'b0, vpl_at);
    vpulse(1'b1, vpl_at);
    chk({15'h0, storage_run_n_n}, 16'h0001, "storage run dropped");
    chk({15'h0, dump_n}, 16'h0001, "dump cleared");
    chk({11'h0, win_n, ident}, 16'h0003, "ident from bitmap");
    vpulse(1'b0, vpl_at);
    chk({8'h00, row_pair}, 16'h0001, "next row pair");
    vpulse(1'b1, vpl_at);
    chk({15'h0, vpl_at}, 16'h0000, "preload on terminate");
    chk({14'h0, image_run_n_n, storage_run_n_n}, 16'h0000, "frame restarts");
    chk({15'h0, dump_n}, 16'h0000, "dump at code zero");
    chk({11'h0, win_n, ident}, 16'h0010, "ids stopped");
    $display("test frame done");
  endtask

  initial begin
    ref_clk_i = 1'b0;
    rst_i = 1'b1;
    vertical_gate_period = 1'b0;
    vend = 1'b0;
    fails = 0;
    n_tests = 0;
    repeat (10) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    t_reset();
    t_access();
    t_run();
    t_frame();
    test_done();
  end

  initial begin
    repeat (3000) @(posedge ref_clk_i);
    fails++;
    $display("mismatch t=%0t run did not finish", $time);
    test_done();
  end
endmodule
